// >>> design/flut7_consts.svh
// constants for lookup-table entry seven: offsets, resets, field positions
// assumes inclusion by the entry module only
`ifndef FLUT7_CONSTS_SVH
`define FLUT7_CONSTS_SVH
`define FLUT7_LIMIT_ADDR 8'h5C
`define FLUT7_DUTY_ADDR 8'h5D
`define FLUT7_LIMIT_RST 8'h7F
`define FLUT7_DUTY_RST 8'h3F
`define FLUT7_HALF_BIT 7
`define FLUT7_WHOLE_HI 6
`define FLUT7_EXT_HI 7
`define FLUT7_EXT_LO 6
`define FLUT7_BASE_HI 5
`define FLUT7_UNMAPPED_RD 8'h00
`define FLUT7_TEMP_SIGN 9
`define FLUT7_TEMP_WHOLE_HI 8
`define FLUT7_TEMP_WHOLE_LO 1
`define FLUT7_SEL_RST 8'h00
`define FLUT7_EXCEED_RST 1'h0
`endif

// >>> design/flut7_pkg.sv
// types for lookup-table entry seven
// assumes nothing beyond the consts header
package flut7_pkg;
  typedef logic [7:0] flut7_byte_t;
  // temperatures in half-degree units
  typedef logic [9:0] flut7_half_deg_t;
endpackage

// >>> design/flut7_entry.sv
// lookup-table entry seven: limit and duty registers, threshold compare
// assumes a register port decoded from the serial interface on the same clock,
// and mode bits and conversion results held by neighbouring logic
// Summary of operation
// - writes accepted only while table unlocked
// - high-res limit: bit7 adds half degree
// - low-res limit: bit7 unused, reads zero
// - above limit selects this entry's duty
// - compare nine bits high-res, eight low-res
// - limit always positive, sign assumed zero
// - table offset added to the limit
// - low-res duty: extended bits read zero
// - high-res duty joins extended and base bits
// - extended bits only at fast pwm rate
// - low-res pwm uses base bits only
`timescale 1ns/1ps
`include "flut7_consts.svh"
module flut7_entry
  import flut7_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic lut_unlock_in,
  input wire logic temp_hires_in,
  input wire logic duty_hires_in,
  input wire logic pwm_fast_in,
  input wire logic [7:0] lut_offset_in,
  input wire logic [9:0] remote_temp_in,
  input wire logic remote_valid_in,
  output logic entry_exceed_out,
  output logic [7:0] entry_duty_out
);

  flut7_byte_t limit_q;
  flut7_byte_t limit_d;
  flut7_byte_t duty_q;
  flut7_byte_t duty_d;
  flut7_byte_t rdata_q;
  flut7_byte_t rdata_d;
  flut7_byte_t duty_sel_q;
  logic exceed_q;
  logic exceed_d;

  // register decode
  wire logic hit_limit = (reg_addr_in == `FLUT7_LIMIT_ADDR);
  wire logic hit_duty = (reg_addr_in == `FLUT7_DUTY_ADDR);
  wire logic wr_limit = reg_wr_in && hit_limit && lut_unlock_in;
  wire logic wr_duty = reg_wr_in && hit_duty && lut_unlock_in;

  // half bit hidden at low resolution
  wire logic half_bit = temp_hires_in && limit_q[`FLUT7_HALF_BIT];
  wire flut7_byte_t limit_view = {half_bit, limit_q[`FLUT7_WHOLE_HI:0]};
  // extended duty bits hidden at low resolution
  wire logic [1:0] ext_view = duty_hires_in ? duty_q[`FLUT7_EXT_HI:`FLUT7_EXT_LO] : 2'h0;
  wire flut7_byte_t duty_view = {ext_view, duty_q[`FLUT7_BASE_HI:0]};

  // limit in half-degree units, sign zero
  wire flut7_half_deg_t limit_half = {2'h0, limit_q[`FLUT7_WHOLE_HI:0], half_bit};
  wire flut7_half_deg_t offset_half = {1'h0, lut_offset_in, 1'h0};
  wire flut7_half_deg_t limit_eff = limit_half + offset_half;
  // low resolution drops the half bit
  wire logic remote_neg = remote_temp_in[`FLUT7_TEMP_SIGN];
  wire logic remote_half = temp_hires_in && remote_temp_in[0];
  wire flut7_half_deg_t remote_half_deg = {1'h0, remote_temp_in[`FLUT7_TEMP_WHOLE_HI:`FLUT7_TEMP_WHOLE_LO], remote_half};
  // equal keeps the lower step, so a reading sitting on the limit does not flip the duty
  // strictly above the effective limit
  wire logic above = !remote_neg && (remote_half_deg > limit_eff);

  // extended bits need the fast pwm rate
  wire logic ext_on = duty_hires_in && pwm_fast_in;
  wire flut7_byte_t duty_eff = ext_on ? duty_q : {2'h0, duty_q[`FLUT7_BASE_HI:0]};

  assign limit_d = wr_limit ? reg_wdata_in : limit_q;
  assign duty_d = wr_duty ? reg_wdata_in : duty_q;
  assign exceed_d = remote_valid_in ? above : exceed_q;
  assign rdata_d = !reg_rd_in ? rdata_q :
                   hit_limit ? limit_view :
                   hit_duty ? duty_view : `FLUT7_UNMAPPED_RD;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      limit_q <= `FLUT7_LIMIT_RST;
      duty_q <= `FLUT7_DUTY_RST;
    end else begin
      limit_q <= limit_d;
      duty_q <= duty_d;
    end
  end

  // read data holds until the next read so slow serial logic can shift it out
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rdata_q <= `FLUT7_UNMAPPED_RD;
      exceed_q <= `FLUT7_EXCEED_RST;
      duty_sel_q <= `FLUT7_SEL_RST;
    end else begin
      rdata_q <= rdata_d;
      exceed_q <= exceed_d;
      duty_sel_q <= duty_eff;
    end
  end

  // outputs come straight from flops so neighbouring logic sees no decode glitches
  assign reg_rdata_out = rdata_q;
  assign entry_exceed_out = exceed_q;
  assign entry_duty_out = duty_sel_q;

  default clocking a_cb @(posedge ref_clk_in);
  endclocking
  default disable iff (srst_in);

  a_locked_limit_hold: assert property (
    (reg_wr_in && hit_limit && !lut_unlock_in) |=> $stable(limit_q))
    else $error("limit changed while table locked");

  a_locked_duty_hold: assert property (
    (reg_wr_in && hit_duty && !lut_unlock_in) |=> $stable(duty_q))
    else $error("duty changed while table locked");

  a_unlocked_duty_write: assert property (
    (reg_wr_in && hit_duty && lut_unlock_in) |=> (duty_q == $past(reg_wdata_in)))
    else $error("duty write not taken while unlocked");

  a_unlocked_limit_write: assert property (
    (reg_wr_in && hit_limit && lut_unlock_in) |=> (limit_q == $past(reg_wdata_in)))
    else $error("limit write not taken while unlocked");

  a_read_data_stands: assert property (
    !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");

  a_hires_limit_read: assert property (
    (reg_rd_in && hit_limit && temp_hires_in) |=> (reg_rdata_out == $past(limit_q)))
    else $error("high-res limit read wrong");

  a_hires_equal_holds: assert property (
    (remote_valid_in && temp_hires_in && (lut_offset_in == 8'h00) &&
     (remote_temp_in == {2'h0, limit_q[`FLUT7_WHOLE_HI:0], limit_q[`FLUT7_HALF_BIT]}))
    |=> !entry_exceed_out)
    else $error("reading equal to high-res limit exceeded");

  a_hires_half_above: assert property (
    (remote_valid_in && temp_hires_in && (lut_offset_in == 8'h00) &&
     (remote_temp_in == {2'h0, limit_q[`FLUT7_WHOLE_HI:0], limit_q[`FLUT7_HALF_BIT]} + 10'h001))
    |=> entry_exceed_out)
    else $error("half degree above high-res limit not exceeded");

  a_lowres_half_zero: assert property (
    (reg_rd_in && hit_limit && !temp_hires_in) |=> !reg_rdata_out[7])
    else $error("low-res limit bit7 not zero");

  a_exceed_follows: assert property (
    (remote_valid_in && above) |=> entry_exceed_out ##0 (entry_duty_out == $past(duty_eff)))
    else $error("exceed flag or duty not selected");

  a_lowres_whole_equal: assert property (
    (remote_valid_in && !temp_hires_in &&
     ({1'h0, remote_temp_in[`FLUT7_TEMP_WHOLE_HI:`FLUT7_TEMP_WHOLE_LO]} == limit_eff[9:1]))
    |=> !entry_exceed_out)
    else $error("low-res half bit changed the compare");

  a_lowres_whole_above: assert property (
    (remote_valid_in && !temp_hires_in && !remote_neg &&
     ({1'h0, remote_temp_in[`FLUT7_TEMP_WHOLE_HI:`FLUT7_TEMP_WHOLE_LO]} > limit_eff[9:1]))
    |=> entry_exceed_out)
    else $error("low-res whole degree above limit not exceeded");

  a_negative_below: assert property (
    (remote_valid_in && remote_neg) |=> !entry_exceed_out)
    else $error("negative reading exceeded limit");

  a_offset_shifts: assert property (
    (remote_valid_in && !remote_neg && (remote_half_deg <= limit_eff)) |=> !entry_exceed_out)
    else $error("offset limit not honoured");

  a_lowres_ext_zero: assert property (
    (reg_rd_in && hit_duty && !duty_hires_in) |=> (reg_rdata_out[7:6] == 2'h0))
    else $error("low-res extended duty bits not zero");

  a_hires_duty_read: assert property (
    (reg_rd_in && hit_duty && duty_hires_in) |=> (reg_rdata_out == $past(duty_q)))
    else $error("high-res duty read wrong");

  a_fast_full_duty: assert property (
    (duty_hires_in && pwm_fast_in) |=> (entry_duty_out == $past(duty_q)))
    else $error("full duty not used at fast high-res pwm");

  a_slow_pwm_base: assert property (
    !pwm_fast_in |=> (entry_duty_out[7:6] == 2'h0))
    else $error("extended duty used at slow pwm");

  a_lowres_base_duty: assert property (
    !duty_hires_in |=> (entry_duty_out == {2'h0, $past(duty_q[`FLUT7_BASE_HI:0])}))
    else $error("low-res duty not base bits alone");

  a_exceed_holds: assert property (
    !remote_valid_in |=> $stable(entry_exceed_out))
    else $error("exceed changed without conversion");

  c_locked_write: cover property (reg_wr_in && hit_limit && !lut_unlock_in);
  c_fast_ext_duty: cover property (ext_on && remote_valid_in && above);
  c_offset_cross: cover property (remote_valid_in && above && (lut_offset_in != 8'h00));
  c_exceed_drop: cover property (entry_exceed_out ##1 !entry_exceed_out);

endmodule // flut7_entry

// >>> testbench/fan_lut_entry_seven_tb.sv
// bench for lookup-table entry seven: random register, mode and conversion traffic
// assumes flut7_pkg and flut7_entry compiled first; model lives in this file
`timescale 1ns/1ps
module fan_lut_entry_seven_tb;
  import flut7_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, unl = 0, th = 0, dh = 0, pf = 0, vld = 0, exc, e_ex = 0;
  logic [7:0] adr = 0, wd = 0, off = 0, rdat, duty;
  logic [9:0] tmp = 0;
  logic [31:0] k, r;
  flut7_byte_t lim = 8'h7F, dty = 8'h3F, e_rd = 8'h00, e_du;
  int n_mismatch = 0, checks_done = 0, seed = 32'hC41B, le;
  always #4 clk = ~clk;
  flut7_entry DUT(.ref_clk_in(clk), .srst_in(rst), .reg_addr_in(adr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wd), .reg_rdata_out(rdat), .lut_unlock_in(unl), .temp_hires_in(th), .duty_hires_in(dh),
    .pwm_fast_in(pf), .lut_offset_in(off), .remote_temp_in(tmp), .remote_valid_in(vld),
    .entry_exceed_out(exc), .entry_duty_out(duty));
  task chk(string n, flut7_byte_t e, flut7_byte_t g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // read view masks the unused bits per mode, stored bits survive
  function flut7_byte_t view(logic [7:0] a);
    if (a == 8'h5C) return th ? lim : {1'h0, lim[6:0]};
    if (a == 8'h5D) return dh ? dty : {2'h0, dty[5:0]};
    return 8'h00;
  endfunction
  task print_verdict();
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (16) @(negedge clk);
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk);
      if (i > 0) begin
        chk("rdata", e_rd, rdat); // register view
        chk("duty", e_du, duty); // duty select
        chk("exceed", {7'h00, e_ex}, {7'h00, exc}); // compare
      end
      // corner: a second reset in mid-run
      rst = (i == 1500) || (i == 1501);
      k = $random(seed);
      r = $random(seed);
      wr = k[1:0] == 2'h0;
      rd = k[1:0] == 2'h1;
      vld = k[1:0] == 2'h2;
      adr = k[3] ? {7'h2E, k[2]} : k[15:8];
      wd = k[23:16];
      unl = k[24] | k[25];
      if (k[7:4] == 4'h0) {th, dh, pf} = k[30:28];
      off = r[12] ? r[20:13] : 8'h00;
      tmp = r[9:0];
      // boundary: reading equal to the limit or one half degree above
      if (r[31:30] == 2'h0) begin
        off = 8'h00;
        tmp = {2'h0, lim[6:0], th & lim[7]} + r[29];
      end
      le = {lim[6:0], th & lim[7]} + 2 * off;
      if (vld) e_ex = !tmp[9] && ({tmp[8:1], th & tmp[0]} > le);
      if (rd) e_rd = view(adr);
      e_du = (dh & pf) ? dty : {2'h0, dty[5:0]};
      if (wr && unl && adr == 8'h5C) lim = wd;
      if (wr && unl && adr == 8'h5D) dty = wd;
      // reset returns registers and outputs to their reset values
      if (rst) begin
        lim = 8'h7F;
        dty = 8'h3F;
        e_rd = 8'h00;
        e_ex = 1'h0;
        e_du = 8'h00;
      end
    end
    print_verdict();
  end
endmodule // fan_lut_entry_seven_tb
